// ---- logic/pism_consts.vh ----
`ifndef PISM_CONSTS_VH
`define PISM_CONSTS_VH

// Register indices within one port page (byte address = 4 x index)
`define PISM_IDX_STATUS   12'h01B
`define PISM_IDX_MASK     12'h01F
`define PISM_IDX_CTRL0    12'h020

// Address layout of the APB byte address
`define PISM_ADDR_MSB     17
`define PISM_PORT_MSB     17
`define PISM_PORT_LSB     14
`define PISM_IDX_MSB      13
`define PISM_IDX_LSB      2

// Field positions in status and mask
`define PISM_BIT_TS       2
`define PISM_BIT_PHY      1
`define PISM_BIT_ACL      0
`define PISM_SRC_W        3

// Field position in operation control 0
`define PISM_BIT_LOOP     7

// Reset values
`define PISM_RST_STATUS   8'h00
`define PISM_RST_MASK     8'h00
`define PISM_RST_CTRL0    8'h00

// Fill for reserved bits and idle data
`define PISM_RSV_HI       5'h00
`define PISM_RSV_CTRL     7'h00
`define PISM_RD_PAD       24'h000000
`define PISM_RD_ZERO      32'h00000000

`endif

// ---- logic/pism_port.v ----
`timescale 1ns/1ps
`include "pism_consts.vh"

module pism_port #(
  parameter HAS_PHY = 1                   // Port owns an integrated PHY
) (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Event sources
  input  wire       ts_src,               // Timestamp summary level
  input  wire       phy_src,              // PHY summary level
  input  wire       acl_evt,              // Filter counter event pulse
  // Register writes
  input  wire       mask_we,              // Mask write strobe
  input  wire       ctrl_we,              // Control 0 write strobe
  input  wire [7:0] wdata,                // Write byte
  // Register views
  output wire [7:0] status,               // Status read view
  output wire [7:0] mask,                 // Mask read view
  output wire [7:0] ctrl0,                // Control 0 read view
  // Results
  output reg        irq_r,                // Per-port request
  output reg        loop_r                // Local MAC loopback
);

  reg  [2:0] stat_r;                      // Status bits 2..0
  reg  [2:0] mask_r;                      // Mask bits 2..0
  wire       acl_clr;                     // Enable bit toggled
  wire [2:0] stat_nxt;                    // Next status
  wire       gate_phy;                    // Constant PHY presence

  // Reset bytes, cut to the stored bits on purpose
  localparam [7:0] RST_STAT = `PISM_RST_STATUS; // Status reset byte
  localparam [7:0] RST_MASK = `PISM_RST_MASK;   // Mask reset byte
  localparam [7:0] RST_CTRL = `PISM_RST_CTRL0;  // Control 0 reset byte

  assign gate_phy = (HAS_PHY != 0);

  // A write that flips the enable bit clears the filter flag
  assign acl_clr = mask_we &
                   (wdata[`PISM_BIT_ACL] != mask_r[`PISM_BIT_ACL]);

  // Summary bits follow their sources only on PHY ports
  assign stat_nxt[`PISM_BIT_TS]  = gate_phy & ts_src;
  assign stat_nxt[`PISM_BIT_PHY] = gate_phy & phy_src;
  // Sticky filter flag; a new event beats a clear
  assign stat_nxt[`PISM_BIT_ACL] = acl_evt |
                   (stat_r[`PISM_BIT_ACL] & ~acl_clr);

  // Status, mask and loopback storage
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stat_r <= RST_STAT[2:0];
      mask_r <= RST_MASK[2:0];
      loop_r <= RST_CTRL[`PISM_BIT_LOOP];
      irq_r  <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      // Mask bits are plain storage; active low enables
      if (mask_we)
        mask_r <= wdata[2:0];
      if (ctrl_we)
        loop_r <= wdata[`PISM_BIT_LOOP];
      // Enabled status bits OR into one request
      irq_r <= |(stat_r & ~mask_r);
    end
  end

  // Reserved bits read as zero: upper five in status and mask, lower seven in control 0
  assign status = {`PISM_RSV_HI, stat_r};
  assign mask   = {`PISM_RSV_HI, mask_r};
  assign ctrl0  = {loop_r, `PISM_RSV_CTRL};

endmodule

// ---- logic/pism_top.v ----
`timescale 1ns/1ps
`include "pism_consts.vh"

module pism_top #(
  parameter             NPORT     = 3,      // Number of ports
  parameter [NPORT-1:0] PHY_PORTS = 3'b011  // Bit g set: port g+1 has PHY
) (
  // Clock and reset
  input  wire                       clk,
  input  wire                       sys_rst,
  // APB slave
  input  wire                       psel,
  input  wire                       penable,
  input  wire                       pwrite,
  input  wire [`PISM_ADDR_MSB:0]    paddr,
  input  wire [31:0]                pwdata,
  input  wire [3:0]                 pstrb,
  output reg                        pready,
  output reg  [31:0]                prdata,
  output reg                        pslverr,
  // Event sources, bit g is port g+1
  input  wire [NPORT-1:0]           ts_src,
  input  wire [NPORT-1:0]           phy_src,
  input  wire [NPORT-1:0]           acl_evt,
  // Per-port results
  output wire [NPORT-1:0]           port_irq,
  output wire [NPORT-1:0]           port_loop
);

  // Address map of one port page
  //   Bits 17:14: port number, 1 up to NPORT
  //   Bits 13:2: register index, one word apart
  //   Bits 1:0: ignored, word access only
  //   Port number 0 or above NPORT is unmapped
  //   Index other than status, mask, control 0 unmapped
  //   Unmapped: error with ready, zero data, no write

  // Transfer timing on the register bus
  //   Setup cycle: psel high, penable low
  //   First access cycle: request taken, data captured
  //   Second access cycle: ready, read data, error
  //   Write lands at the edge that samples ready
  //   Exactly one wait state, never more or less
  //   Back-to-back setup after ready is fine

  // Event timing per port
  //   Summary levels reach status one edge later
  //   Filter pulse sets its sticky flag one edge later
  //   Port request follows one edge after status
  //   Source to request: two edges in all

  // Clearing the filter flag
  //   Any committed mask write that flips bit 0
  //   Same value again leaves the flag alone
  //   A pulse in the clearing cycle keeps the flag

  // Limitations a user must know
  //   Only byte lane 0 carries register data
  //   Writes with lane 0 disabled are accepted, dropped
  //   Status writes are accepted and dropped
  //   Control 0 keeps only the loopback bit
  //   Summary bits on the port without PHY stay 0

  // Reset, synchronous and active high
  //   Ready, data and error low
  //   All port registers back to zero
  //   First setup may follow the release edge

  // Outputs
  //   Bus answer from three flops below
  //   Request and loopback from flops per port

  // Address decode
  wire [3:0]                   port_sel;  // Port nibble
  wire [11:0]                  reg_idx;   // Register index
  wire                         idx_stat;  // Status selected
  wire                         idx_mask;  // Mask selected
  wire                         idx_ctrl;  // Control 0 selected
  wire                         reg_ok;    // Index is mapped
  wire [NPORT-1:0]             hit;       // Port nibble matches
  wire                         map_ok;    // Whole address mapped
  // Transfer control
  wire                         acc;       // Access phase
  wire                         first;     // First access cycle
  wire                         commit;    // Write takes effect
  wire                         lane0;     // Low byte enabled
  // Read gathering
  wire [8*NPORT-1:0]           rd_all;    // Per-port read bytes
  reg  [7:0]                   rd_byte;   // Selected read byte
  integer                      i;         // Read loop index
  // Write and read qualifiers
  wire [7:0]                   wbyte;     // Low byte of write data
  wire                         rd_ok;     // Mapped read, data returned

  assign port_sel = paddr[`PISM_PORT_MSB:`PISM_PORT_LSB];
  assign reg_idx  = paddr[`PISM_IDX_MSB:`PISM_IDX_LSB];

  // Register index compare
  assign idx_stat = (reg_idx == `PISM_IDX_STATUS);
  assign idx_mask = (reg_idx == `PISM_IDX_MASK);
  assign idx_ctrl = (reg_idx == `PISM_IDX_CTRL0);
  assign reg_ok   = idx_stat | idx_mask | idx_ctrl;
  assign map_ok   = reg_ok & (|hit);

  // Two-cycle access: wait state, then ready
  assign acc    = psel & penable;
  assign first  = acc & ~pready;
  // Write lands only at the edge that samples ready high
  assign commit = acc & pready & pwrite & map_ok & lane0;
  // Narrow data sits in byte lane 0
  assign lane0  = pstrb[0];
  // Only byte lane 0 reaches the registers
  // Lanes 1 to 3 are ignored
  assign wbyte  = pwdata[7:0];
  // Reads of mapped registers return the byte
  assign rd_ok  = map_ok & ~pwrite;

  // One copy of the port logic per port
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1)
    begin : gen_port
      localparam integer PNUM = g + 1;    // Port number in nibble
      wire [7:0] st_v;                    // Status view
      wire [7:0] mk_v;                    // Mask view
      wire [7:0] c0_v;                    // Control view
      wire       mk_we;                   // Mask write strobe
      wire       c0_we;                   // Control write strobe

      // Port nibble match; compared at full width
      assign hit[g] = ({28'h0000000, port_sel} == PNUM);

      // Status has no write path: writes there are dropped
      assign mk_we = commit & hit[g] & idx_mask;
      // Loopback bit written through control 0
      assign c0_we = commit & hit[g] & idx_ctrl;

      // Per-port register byte
      // Index decode is shared by all ports
      // Unused index gives zero
      assign rd_all[8*g +: 8] = idx_stat ? st_v :
                                idx_mask ? mk_v :
                                idx_ctrl ? c0_v : 8'h00;

      pism_port #(
        .HAS_PHY (PHY_PORTS[g])
      ) u_port (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ts_src  (ts_src[g]),
        .phy_src (phy_src[g]),
        .acl_evt (acl_evt[g]),
        .mask_we (mk_we),
        .ctrl_we (c0_we),
        .wdata   (wbyte),
        .status  (st_v),
        .mask    (mk_v),
        .ctrl0   (c0_v),
        .irq_r   (port_irq[g]),
        .loop_r  (port_loop[g])
      );
    end
  endgenerate

  // Pick the byte of the addressed port
  // Port hits are one-hot by construction
  // No hit: zero byte, refused anyway
  always @*
  begin
    // Default keeps the process free of latches
    rd_byte = 8'h00;
    for (i = 0; i < NPORT; i = i + 1)
    begin
      // Only one hit can be set
      if (hit[i])
        rd_byte = rd_all[8*i +: 8];
    end
  end

  // Ready: one cycle, in the second access cycle
  always @(posedge clk)
  begin
    if (sys_rst)
      pready <= 1'b0;                     // Idle after reset
    else
      pready <= first;                    // One wait state
  end

  // Error flag: stands only with ready
  always @(posedge clk)
  begin
    if (sys_rst)
      pslverr <= 1'b0;                    // No error after reset
    else if (first)
      pslverr <= ~map_ok;                 // Unmapped address refused
    else
      pslverr <= 1'b0;                    // Cleared outside ready
  end

  // Read data: captured in the first access cycle
  always @(posedge clk)
  begin
    if (sys_rst)
      prdata <= `PISM_RD_ZERO;            // Zero after reset
    else if (first)
    begin
      // Mapped read returns the byte, upper bits zero
      if (rd_ok)
        prdata <= {`PISM_RD_PAD, rd_byte};
      else
        prdata <= `PISM_RD_ZERO;          // Writes, refusals read zero
    end
  end

endmodule

// ---- sim/pism_host.sv ----
`timescale 1ns/1ps
// Host software: one APB transfer at a time
module pism_host (
  // Clock
  input  wire         clk,
  // Requests
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [17:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  // Answers
  input  wire         pready,
  input  wire         pslverr,
  input  wire [31:0]  prdata
);
  // Idle bus from time zero
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Setup, access, hold until pready is sampled, then release
  task xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
            output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- sim/pism_top_chk.sv ----
`timescale 1ns/1ps
// Bus timing and register behaviour seen at the block's ports
module pism_chk #(
  parameter             NPORT     = 3,
  parameter [NPORT-1:0] PHY_PORTS = 3'b011
) (
  // Clock and reset
  input wire             clk,
  input wire             sys_rst,
  // APB
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire             pready,
  input wire             pslverr,
  input wire [17:0]      paddr,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire [3:0]       pstrb,
  // Sources and results
  input wire [NPORT-1:0] ts_src,
  input wire [NPORT-1:0] phy_src,
  input wire [NPORT-1:0] acl_evt,
  input wire [NPORT-1:0] port_irq,
  input wire [NPORT-1:0] port_loop
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [3:0]  pn = paddr[17:14];     // Port field
  wire [11:0] ix = paddr[13:2];      // Register index
  wire        wr = pready && pwrite; // Write commits here
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_rsv_zero: assert property (
    pready && ix != 12'h020 |-> prdata[31:3] == 29'h0) else $error("rsv set");
  a_mac_quiet: assert property (
    pready && pn == 4'h3 && ix == 12'h01B |-> prdata[2:1] == 2'h0)
    else $error("MAC status");
  a_addr_unmapped: assert property (
    pready && (pn == 4'h0 || pn > 4'h3) |-> pslverr && prdata == 32'h0)
    else $error("no refusal");
  a_loop_cause: assert property (
    $changed(port_loop) |-> $past(wr && ix == 12'h020)) else $error("loop");
  a_loop_value: assert property (
    $past(wr && pstrb[0] && ix == 12'h020 && pn == 4'h1)
    |-> port_loop[0] == $past(pwdata[7])) else $error("loop value");
  a_mac_irq: assert property (
    $rose(port_irq[2]) |-> $past(acl_evt[2], 2) || $past(wr, 2))
    else $error("MAC irq");
endmodule
bind pism_top pism_chk #(.NPORT(NPORT), .PHY_PORTS(PHY_PORTS)) u_pism_chk (
  .clk, .sys_rst, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
  .pwdata, .prdata, .pstrb, .ts_src, .phy_src, .acl_evt, .port_irq,
  .port_loop);

// ---- sim/test_pism_top.sv ----
`timescale 1ns/1ps
`include "pism_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module test_pism_top;
  logic clk = 1'b0, sys_rst = 1'b1, psel, penable, pwrite, pready, pslverr;
  logic err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic [2:0]  ts_src = 3'h0, phy_src = 3'h0, acl_evt = 3'h0;
  logic [2:0]  port_irq, port_loop;
  int fails = 0, n_checks = 0, cyc = 0;
  localparam [11:0] ST = `PISM_IDX_STATUS, MK = `PISM_IDX_MASK;
  localparam [11:0] C0 = `PISM_IDX_CTRL0;
  always #12.5 clk = ~clk;
  pism_top u_pism_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .ts_src, .phy_src,
    .acl_evt, .port_irq, .port_loop);
  pism_host u_pism_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr);
  // Write d, or read and expect d, at register i of port p
  task acc(input int p, input logic [11:0] i, input logic w,
           input logic [7:0] d);
    u_pism_host.xfer(w, {p[3:0], i, 2'b00}, d, rdv, err);
    if (!w) `CHK({err, rdv}, {1'b0, 24'h000000, d})
  endtask
  // Let n edges pass
  task tick(input int n); repeat (n) @(posedge clk); endtask
  // One-cycle filter event on the MAC port
  task acl3; acl_evt <= 3'h4; tick(1); acl_evt <= 3'h0; tick(2); endtask
  // Reset values, reserved bits, mask storage
  task t_regs;
    for (int p = 1; p <= 3; p++) acc(p, ST, 1'b0, 8'h00);
    for (int p = 1; p <= 3; p++) acc(p, MK, 1'b0, 8'h00);
    for (int p = 1; p <= 3; p++) acc(p, C0, 1'b0, 8'h00);
    acc(1, MK, 1'b1, 8'hFF);
    acc(1, MK, 1'b0, 8'h07);
    acc(1, MK, 1'b1, 8'h00);
  endtask
  // Summary sources, MAC port and enables
  task t_src;
    ts_src <= 3'h5;
    phy_src <= 3'h7;
    tick(3);
    `CHK(port_irq, 3'h3)
    acc(1, ST, 1'b0, 8'h06);
    acc(3, ST, 1'b0, 8'h00);
    acc(1, MK, 1'b1, 8'h02);
    acc(2, MK, 1'b1, 8'h02);
    tick(2);
    `CHK(port_irq, 3'h1)
    acc(1, MK, 1'b1, 8'h06);
    tick(2);
    `CHK(port_irq, 3'h0)
    {ts_src, phy_src} <= 6'h00;
    acc(1, MK, 1'b1, 8'h00);
    acc(2, MK, 1'b1, 8'h00);
  endtask
  // Filter event latch, cleared only by toggling its enable
  task t_acl;
    acl3;
    `CHK(port_irq, 3'h4)
    acc(3, ST, 1'b1, 8'h00);
    acc(3, MK, 1'b1, 8'h00);
    acc(3, ST, 1'b0, 8'h01);
    acc(3, MK, 1'b1, 8'h01);
    acc(3, ST, 1'b0, 8'h00);
    acl3;
    `CHK(port_irq, 3'h0)
    acc(3, MK, 1'b1, 8'h00);
    acc(3, ST, 1'b0, 8'h00);
  endtask
  // Loopback bit and a refused address
  task t_loop;
    acc(1, C0, 1'b1, 8'h80);
    acc(2, C0, 1'b1, 8'hFF);
    acc(2, C0, 1'b0, 8'h80);
    `CHK(port_loop, 3'h3)
    u_pism_host.xfer(1'b0, {4'h0, ST, 2'b00}, 8'h00, rdv, err);
    `CHK({err, rdv}, {1'b1, 32'h00000000})
    acc(1, C0, 1'b1, 8'h00);
    acc(2, C0, 1'b1, 8'h00);
    tick(1);
    `CHK(port_loop, 3'h0)
  endtask
  // Verdict and end of run
  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict;
    end
  end
  // Main sequence
  initial
  begin
    tick(20);
    sys_rst <= 1'b0;
    t_regs;
    t_src;
    t_acl;
    t_loop;
    give_verdict;
  end
endmodule
